/* aswa_consts.svh */
// Purpose: Register offsets, field positions and reset values of the slave port arbiter
// Assumes: Register addresses are byte addresses on the plain register port
// Notes: Definitions only, included by the register block and the arbiter top
`ifndef ASWA_CONSTS_SVH
`define ASWA_CONSTS_SVH

// Register offsets
`define ASWA_OFF_WEIGHT_A 8'h00
`define ASWA_OFF_WEIGHT_B 8'h04
`define ASWA_OFF_LATENCY 8'h08
`define ASWA_OFF_STATUS 8'h0C

// Field geometry
`define ASWA_WF_BITS 5
`define ASWA_LF_BITS 3
`define ASWA_WF_LO_LSB 0
`define ASWA_WF_HI_LSB 8
`define ASWA_LF_A_LSB 0
`define ASWA_LF_B_LSB 8

// Reset values: weight of one, latency field 0 meaning one cycle
`define ASWA_WEIGHT_RST 5'h01
`define ASWA_LAT_RST 3'h0

// Weight field zero stands for the largest weight
`define ASWA_WEIGHT_MAX 6'h20

// Status register layout
`define ASWA_ST_OWNER_LSB 0
`define ASWA_ST_BUSY_BIT 3
`define ASWA_ST_PTR_LSB 4
`define ASWA_ST_LOCK_BIT 6
`define ASWA_ST_IDLE_BIT 7

`endif

/* aswa_pkg.sv */
// Purpose: Types shared by the slave port arbiter files
// Assumes: Master codes index the request and lock vectors
// Notes: Constants live in aswa_consts.svh
package aswa_pkg;

    // Master codes, also bit positions in request vectors
    typedef enum logic [2:0] {
        MST_SYSTEM_CONTROLLER = 3'h0,
        MST_HIGH_PERF_DMA = 3'h1,
        MST_FABRIC_IF_A = 3'h2,
        MST_FABRIC_IF_B = 3'h3,
        MST_PERIPHERAL_DMA = 3'h4
    } aswa_mst_e;

    // Kind of slave behind this port
    typedef enum logic [1:0] {
        SLV_OTHER = 2'h0,
        SLV_SRAM_A = 2'h1,
        SLV_SRAM_B = 2'h2
    } aswa_slave_e;

    // Arbiter state, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_OWN = 2'h2
    } aswa_state_e;

    typedef logic [5:0] aswa_cnt_t;

endpackage

/* aswa_rr_pick.sv */
// Purpose: Rotating pick among the four weighted masters
// Assumes: Pointer names the position that is looked at first
// Notes: Purely combinational
`timescale 1ns/1ps
module aswa_rr_pick (
    // Requests of weighted masters, bit 0 is the high performance DMA
    input wire logic [3:0] i_req,
    input wire logic [1:0] i_ptr,
    // Winner
    output logic [1:0] o_idx,
    output logic o_vld
);

    // Walk from the far end so the nearest requester is kept last
    always_comb begin
        logic [1:0] pos;
        pos = 2'h0;
        o_idx = 2'h0;
        o_vld = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            pos = 2'(i_ptr + 2'(i));
            if (i_req[pos]) begin
                o_idx = pos;
                o_vld = 1'b1;
            end
        end
    end

endmodule

/* aswa_cfg_regs.sv */
// Purpose: Weight and latency registers with a status readback
// Assumes: Plain register port, read data valid only in the cycle after the strobe
// Notes: Unmapped addresses read zero and ignore writes
`timescale 1ns/1ps
`include "aswa_consts.svh"
module aswa_cfg_regs (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Block state and configuration
    input wire logic [7:0] i_status,
    output logic [19:0] o_weight_cfg,
    output logic [5:0] o_lat_cfg
);

    logic [3:0][4:0] weight_q;
    logic [1:0][2:0] lat_q;

    // Writes take effect at once, even while arbitrating
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            weight_q <= {4{`ASWA_WEIGHT_RST}};
            lat_q <= {2{`ASWA_LAT_RST}};
        end else if (i_ce && i_reg_wr) begin
            if (i_reg_addr == `ASWA_OFF_WEIGHT_A) begin
                weight_q[0] <= i_reg_wdata[`ASWA_WF_LO_LSB +: `ASWA_WF_BITS];
                weight_q[1] <= i_reg_wdata[`ASWA_WF_HI_LSB +: `ASWA_WF_BITS];
            end
            if (i_reg_addr == `ASWA_OFF_WEIGHT_B) begin
                weight_q[2] <= i_reg_wdata[`ASWA_WF_LO_LSB +: `ASWA_WF_BITS];
                weight_q[3] <= i_reg_wdata[`ASWA_WF_HI_LSB +: `ASWA_WF_BITS];
            end
            if (i_reg_addr == `ASWA_OFF_LATENCY) begin
                lat_q[0] <= i_reg_wdata[`ASWA_LF_A_LSB +: `ASWA_LF_BITS];
                lat_q[1] <= i_reg_wdata[`ASWA_LF_B_LSB +: `ASWA_LF_BITS];
            end
        end
    end

    // Read data stand one cycle, zero otherwise
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h0;
        end else if (i_ce) begin
            o_reg_rdata <= 32'h0;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    `ASWA_OFF_WEIGHT_A: o_reg_rdata <= {19'h0, weight_q[1], 3'h0, weight_q[0]};
                    `ASWA_OFF_WEIGHT_B: o_reg_rdata <= {19'h0, weight_q[3], 3'h0, weight_q[2]};
                    `ASWA_OFF_LATENCY: o_reg_rdata <= {21'h0, lat_q[1], 5'h0, lat_q[0]};
                    `ASWA_OFF_STATUS: o_reg_rdata <= {24'h0, i_status};
                    default: o_reg_rdata <= 32'h0;
                endcase
            end
        end
    end

    assign o_weight_cfg = weight_q;
    assign o_lat_cfg = lat_q;

endmodule

/* aswa_arbiter.sv */
// Purpose: Arbiter of one slave port of a multi-layer AHB-Lite matrix
// Assumes: Requests, locks and HREADY come from logic on the same clock
// Notes: Grant is registered and takes effect in the cycle after the decision
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "aswa_consts.svh"
module aswa_arbiter #(
    parameter aswa_pkg::aswa_slave_e SLAVE_KIND = aswa_pkg::SLV_SRAM_A
) (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Master side, bit index is the master code
    input wire logic [4:0] i_req,
    input wire logic [4:0] i_lock,
    // Slave side of the current transfer
    input wire logic i_hready,
    input wire logic i_hwrite,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Grant and status
    output logic [4:0] o_grant,
    output logic [2:0] o_owner,
    output logic o_idle_ins
);

    // Weight field decode, zero stands for the top weight
    function automatic aswa_pkg::aswa_cnt_t weight_of(input logic [4:0] fld);
        return (fld == 5'h00) ? `ASWA_WEIGHT_MAX : {1'b0, fld};
    endfunction

    // Smaller of two counts
    function automatic aswa_pkg::aswa_cnt_t min_cnt(input aswa_pkg::aswa_cnt_t a, input aswa_pkg::aswa_cnt_t b);
        return (a < b) ? a : b;
    endfunction

    localparam logic IS_SRAM = (SLAVE_KIND != aswa_pkg::SLV_OTHER);

    aswa_pkg::aswa_state_e state_q;
    aswa_pkg::aswa_mst_e own_q;
    aswa_pkg::aswa_cnt_t cnt_q;
    logic [1:0] ptr_q;
    logic last_wr_q;
    logic [4:0] grant_q;
    logic idle_q;

    logic [19:0] weight_cfg;
    logic [5:0] lat_cfg;
    logic [7:0] status;
    logic [2:0] own_bits;
    logic [1:0] own_wrr_idx;
    logic own_busy;
    logic own_wrr;
    logic own_req;
    logic own_lock;
    aswa_pkg::aswa_cnt_t own_weight;
    aswa_pkg::aswa_cnt_t lat_c;
    aswa_pkg::aswa_cnt_t allow;
    logic beat_raw;
    logic gap;
    logic beat;
    logic done;
    logic release_c;
    logic [1:0] pk_idx;
    logic pk_vld;
    logic nxt_vld;
    aswa_pkg::aswa_mst_e nxt_own;
    logic [1:0] ptr_after;
    logic [1:0] pick_ptr;

    // Configuration registers and status readback
    aswa_cfg_regs u_cfg (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata),
        .i_status(status),
        .o_weight_cfg(weight_cfg),
        .o_lat_cfg(lat_cfg)
    );

    // Second level: rotation among weighted masters
    aswa_rr_pick u_pick (
        .i_req(i_req[4:1]),
        .i_ptr(pick_ptr),
        .o_idx(pk_idx),
        .o_vld(pk_vld)
    );

    // Owner decode
    assign own_bits = own_q;
    assign own_wrr_idx = 2'(own_bits - 3'h1);
    assign own_busy = (state_q == aswa_pkg::ST_OWN);
    assign own_wrr = own_busy && (own_q != aswa_pkg::MST_SYSTEM_CONTROLLER);
    assign own_req = i_req[own_bits];
    assign own_lock = own_busy && i_lock[own_bits];
    // Index of the next weighted master wraps from the last one to the first
    assign ptr_after = own_bits[1:0];
    // A releasing weighted owner is looked at last, so it must rearbitrate behind the others
    assign pick_ptr = (own_wrr && release_c) ? ptr_after : ptr_q;

    // Allowance of the current owner, read live so rewrites apply at once
    always_comb begin
        own_weight = weight_of(weight_cfg[own_wrr_idx*5 +: 5]);
        if (SLAVE_KIND == aswa_pkg::SLV_SRAM_B) begin
            lat_c = aswa_pkg::aswa_cnt_t'({3'h0, lat_cfg[5:3]}) + 6'h01;
        end else begin
            lat_c = aswa_pkg::aswa_cnt_t'({3'h0, lat_cfg[2:0]}) + 6'h01;
        end
        if (own_q == aswa_pkg::MST_SYSTEM_CONTROLLER) begin
            allow = 6'h01;
        end else if (IS_SRAM) begin
            allow = min_cnt(own_weight, lat_c);
        end else begin
            allow = own_weight;
        end
    end

    // Beat accounting; the SRAM turnaround cycle is not a transfer
    assign beat_raw = own_busy && i_hready && own_req;
    assign gap = IS_SRAM && last_wr_q && beat_raw && !i_hwrite;
    assign beat = beat_raw && !gap;
    assign done = beat && ((cnt_q + 6'h01) >= allow);

    // Free for rearbitration: idle, allotment spent, or owner gone; a lock overrides both
    // An allowance already spent under lock is given up as soon as the lock ends
    assign release_c = !own_busy || (!own_lock && (done || !own_req || (cnt_q >= allow)));

    // First level: fixed master ahead of the rotation
    assign nxt_vld = i_req[0] || pk_vld;
    assign nxt_own = i_req[0] ? aswa_pkg::MST_SYSTEM_CONTROLLER
                              : aswa_pkg::aswa_mst_e'(3'({1'b0, pk_idx}) + 3'h1);

    // Ownership and state
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= aswa_pkg::ST_IDLE;
            own_q <= aswa_pkg::MST_SYSTEM_CONTROLLER;
        end else if (i_ce && release_c) begin
            unique case (1'b1)
                nxt_vld: begin
                    state_q <= aswa_pkg::ST_OWN;
                    own_q <= nxt_own;
                end
                default: begin
                    state_q <= aswa_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Transfer count of the current tenure, held at top while locked
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 6'h00;
        end else if (i_ce) begin
            if (release_c) begin
                cnt_q <= 6'h00;
            end else if (beat && (cnt_q != 6'h3F)) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    // Rotation pointer moves only when a weighted owner lets go
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ptr_q <= 2'h0;
        end else if (i_ce && own_wrr && release_c) begin
            ptr_q <= ptr_after;
        end
    end

    // Last counted beat direction for the SRAM turnaround
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_wr_q <= 1'b0;
            idle_q <= 1'b0;
        end else if (i_ce) begin
            idle_q <= gap;
            if (gap) begin
                last_wr_q <= 1'b0;
            end else if (beat) begin
                last_wr_q <= i_hwrite;
            end
        end
    end

    // One-hot grant registered with the owner
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            grant_q <= 5'h00;
        end else if (i_ce && release_c) begin
            grant_q <= nxt_vld ? 5'(5'h01 << nxt_own) : 5'h00;
        end
    end

    assign status = {idle_q, own_lock, ptr_q, own_busy, own_bits};
    assign o_grant = grant_q;
    assign o_owner = own_q;
    assign o_idle_ins = idle_q;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    property p_sys_first;
        i_ce && release_c && i_req[0] |=> own_busy && own_q == aswa_pkg::MST_SYSTEM_CONTROLLER;
    endproperty
    a_sys_first: assert property (p_sys_first) else $error("fixed master lost a free slave");

    property p_skip_idle;
        i_ce && release_c && nxt_vld |-> i_req[nxt_own];
    endproperty
    a_skip_idle: assert property (p_skip_idle) else $error("grant to a non-requesting master");

    property p_lock_keep;
        i_ce && own_lock |=> own_busy && own_q == $past(own_q);
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("locked owner lost the slave");

    property p_allow_cap;
        own_busy && !own_lock && !$past(own_lock) && !i_reg_wr |-> cnt_q < allow;
    endproperty
    a_allow_cap: assert property (p_allow_cap) else $error("owner exceeded its allowance");

    property p_advance;
        i_ce && own_wrr && done && !own_lock |=> ptr_q == $past(ptr_after) && cnt_q == 6'h00;
    endproperty
    a_advance: assert property (p_advance) else $error("rotation did not advance");

    property p_sys_no_rotate;
        own_busy && !own_wrr |=> $stable(ptr_q);
    endproperty
    a_sys_no_rotate: assert property (p_sys_no_rotate) else $error("fixed master moved the rotation");

    property p_full_weight;
        i_ce && own_wrr && beat && !done |=> own_busy && own_q == $past(own_q);
    endproperty
    a_full_weight: assert property (p_full_weight) else $error("weighted owner interrupted early");

    property p_lat_cap;
        IS_SRAM && own_wrr && !own_lock && !$past(own_lock) && !i_reg_wr |-> cnt_q < lat_c;
    endproperty
    a_lat_cap: assert property (p_lat_cap) else $error("latency limit overrun");

    property p_gap;
        i_ce && gap |=> o_idle_ins && !last_wr_q;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle after write");

    property p_sys_one;
        i_ce && own_busy && !own_wrr && beat && !own_lock |=> cnt_q == 6'h00;
    endproperty
    a_sys_one: assert property (p_sys_one) else $error("fixed master held more than one beat");

endmodule

/* aswa_bus_model.sv */
// Purpose: Behavioural masters and slave around one arbiter port
// Assumes: Bench loads a burst length per master; grant is one-hot
// Notes: Slave answers every cycle, or only every other cycle when slow
`timescale 1ns/1ps
module aswa_bus_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Bench control
    input wire logic [4:0] i_load,
    input wire logic [29:0] i_beats,
    input wire logic [4:0] i_lock_mask,
    input wire logic i_slow,
    // Arbiter side
    input wire logic [4:0] i_grant,
    output logic [4:0] o_req,
    output logic [4:0] o_lock,
    output logic o_hready,
    output logic o_hwrite
);
    logic [5:0] rem_q [5];
    logic tog_q;

    // Request held for the whole burst, dropped after the last beat
    always_comb begin
        for (int m = 0; m < 5; m++) begin
            o_req[m] = (rem_q[m] != 6'h00);
        end
    end

    // Lock only while the locked burst lasts
    assign o_lock = o_req & i_lock_mask;
    assign o_hwrite = 1'b0;
    // Slow slave stretches beats, grant must not move meanwhile
    assign o_hready = !i_slow || tog_q;

    // Beat counting per master
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tog_q <= 1'b0;
            for (int m = 0; m < 5; m++) begin
                rem_q[m] <= 6'h00;
            end
        end else begin
            tog_q <= !tog_q;
            for (int m = 0; m < 5; m++) begin
                if (i_load[m]) begin
                    rem_q[m] <= i_beats[m*6 +: 6];
                end else if (i_grant[m] && o_hready && o_req[m]) begin
                    rem_q[m] <= rem_q[m] - 6'h01;
                end
            end
        end
    end
endmodule

/* aswa_arbiter_tb.sv */
// Purpose: Self-checking bench, an SRAM port and an other-slave port side by side
// Assumes: Both arbiters share the register port and burst control
// Notes: Owner of every completed beat is logged and compared as a sequence
`timescale 1ns/1ps
module aswa_arbiter_tb;
    localparam logic [2:0] SC = aswa_pkg::MST_SYSTEM_CONTROLLER;
    localparam logic [2:0] HP = aswa_pkg::MST_HIGH_PERF_DMA;
    localparam logic [2:0] FA = aswa_pkg::MST_FABRIC_IF_A;
    localparam logic [2:0] FB = aswa_pkg::MST_FABRIC_IF_B;
    localparam logic [2:0] PD = aswa_pkg::MST_PERIPHERAL_DMA;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rdata;
    logic [4:0] load = 5'h00;
    logic [29:0] beats = 30'h00000000;
    logic [4:0] lock_mask = 5'h00;
    logic slow = 1'b0;
    logic [4:0] gnt0, gnt1, req0, req1, lk0, lk1;
    logic [2:0] own0, own1;
    logic hr0, hr1, hw0, hw1;
    logic [2:0] seq0 [$];
    logic [2:0] seq1 [$];
    logic [2:0] expq [$];
    int miscompares = 0;
    int checks = 0;

    // 20 MHz clock
    always #25 i_core_clk = !i_core_clk;

    // SRAM port, its masters and slave
    aswa_arbiter #(.SLAVE_KIND(aswa_pkg::SLV_SRAM_A)) i_aswa_arbiter (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_req(req0), .i_lock(lk0), .i_hready(hr0),
        .i_hwrite(hw0), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata), .o_grant(gnt0), .o_owner(own0), .o_idle_ins()
    );
    aswa_bus_model i_aswa_bus_model (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_load(load), .i_beats(beats), .i_lock_mask(lock_mask),
        .i_slow(slow), .i_grant(gnt0), .o_req(req0), .o_lock(lk0), .o_hready(hr0), .o_hwrite(hw0)
    );
    // Other-slave port, same register writes
    aswa_arbiter #(.SLAVE_KIND(aswa_pkg::SLV_OTHER)) i_aswa_arbiter_oth (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_req(req1), .i_lock(lk1), .i_hready(hr1),
        .i_hwrite(hw1), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(), .o_grant(gnt1), .o_owner(own1), .o_idle_ins()
    );
    aswa_bus_model i_aswa_bus_model_oth (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_load(load), .i_beats(beats), .i_lock_mask(lock_mask),
        .i_slow(slow), .i_grant(gnt1), .o_req(req1), .o_lock(lk1), .o_hready(hr1), .o_hwrite(hw1)
    );

    // Log the owner of each completed beat
    always @(posedge i_core_clk) begin
        if ((gnt0 & req0) != 5'h00 && hr0) seq0.push_back(own0);
        if ((gnt1 & req1) != 5'h00 && hr1) seq1.push_back(own1);
    end

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Compares a logged beat sequence against expq
    task automatic chk_seq(input string nm, input int which);
        logic [2:0] got [$];
        got = seq1;
        if (which == 0) got = seq0;
        checks++;
        if (got.size() != expq.size()) begin
            miscompares++;
            $display("BAD %s length expected %0d seen %0d", nm, expq.size(), got.size());
        end else begin
            foreach (got[i]) begin
                if (got[i] !== expq[i]) begin
                    miscompares++;
                    $display("BAD %s beat %0d expected %h seen %h", nm, i, expq[i], got[i]);
                end
            end
        end
        expq.delete();
    endtask

    task automatic ex(input logic [2:0] code, input int n);
        repeat (n) expq.push_back(code);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge i_core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge i_core_clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Masters stay idle ten cycles around every configuration change
    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        tick(10);
        reg_write(a, d);
        tick(10);
    endtask

    function automatic logic [4:0] nz(input logic [29:0] b);
        for (int m = 0; m < 5; m++) nz[m] = (b[m*6 +: 6] != 6'h00);
    endfunction

    function automatic logic [29:0] bt(input int sc, input int hp, input int fa, input int fb, input int pd);
        return {pd[5:0], fb[5:0], fa[5:0], hp[5:0], sc[5:0]};
    endfunction

    // Start bursts, add late ones after the first beat, wait for all to end
    task automatic run(input logic [29:0] b, input logic [29:0] lb, input logic [4:0] lk);
        int n;
        seq0.delete();
        seq1.delete();
        n = 0;
        @(posedge i_core_clk);
        lock_mask <= lk;
        beats <= b;
        load <= nz(b);
        @(posedge i_core_clk);
        load <= 5'h00;
        tick(1);
        while (lb != 30'h00000000 && seq0.size() == 0 && n < 50) begin
            tick(1);
            n++;
        end
        if (lb != 30'h00000000) begin
            beats <= lb;
            load <= nz(lb);
            @(posedge i_core_clk);
            load <= 5'h00;
            tick(1);
        end
        while ((req0 | req1) != 5'h00 && n < 400) begin
            tick(1);
            n++;
        end
        if (n >= 400) begin
            miscompares++;
            $display("BAD burst completion expected done seen hang");
            test_done();
        end
        lock_mask <= 5'h00;
        tick(3);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        reg_read(8'h00, d);
        chk_val("weight_config_reg_a", 32'h00000101, d);
        reg_read(8'h04, d);
        chk_val("weight_config_reg_b", 32'h00000101, d);
        reg_read(8'h08, d);
        chk_val("sram_latency_limit_reg", 32'h00000000, d);
        cfg(8'h10, 32'hFFFFFFFF);
        reg_read(8'h10, d);
        chk_val("unmapped", 32'h00000000, d);
        cfg(8'h04, 32'hFFFFFFFF);
        reg_read(8'h04, d);
        chk_val("weight field width", 32'h00001F1F, d);
        cfg(8'h04, 32'h00000101);
        $display("test regs done");
    endtask

    // Rotation from the start, slow slave
    task automatic t_rr();
        slow <= 1'b1;
        run(bt(0, 1, 1, 1, 1), 30'h00000000, 5'h00);
        slow <= 1'b0;
        ex(HP, 1);
        ex(FA, 1);
        ex(FB, 1);
        ex(PD, 1);
        chk_seq("rotation sram", 0);
        ex(HP, 1);
        ex(FA, 1);
        ex(FB, 1);
        ex(PD, 1);
        chk_seq("rotation other", 1);
        $display("test rr done");
    endtask

    task automatic t_skip();
        run(bt(0, 0, 1, 1, 0), 30'h00000000, 5'h00);
        ex(FA, 1);
        ex(FB, 1);
        chk_seq("skip idle", 0);
        $display("test skip done");
    endtask

    // System controller first, rotation then resumes at the peripheral DMA
    task automatic t_fixed();
        run(bt(2, 1, 1, 1, 1), 30'h00000000, 5'h00);
        ex(SC, 2);
        ex(PD, 1);
        ex(HP, 1);
        ex(FA, 1);
        ex(FB, 1);
        chk_seq("fixed then resume", 0);
        $display("test fixed done");
    endtask

    // Weight 8, SRAM limit 4, system controller arrives mid-burst
    task automatic t_weight();
        logic [31:0] d;
        cfg(8'h04, 32'h00000801);
        cfg(8'h08, 32'h00000003);
        reg_read(8'h08, d);
        chk_val("latency field", 32'h00000003, d);
        run(bt(0, 0, 0, 0, 12), bt(4, 0, 0, 0, 0), 5'h00);
        ex(PD, 4);
        ex(SC, 4);
        ex(PD, 8);
        chk_seq("sram latency cap", 0);
        ex(PD, 8);
        ex(SC, 4);
        ex(PD, 4);
        chk_seq("other full weight", 1);
        $display("test weight done");
    endtask

    task automatic t_lock();
        run(bt(0, 3, 1, 0, 0), 30'h00000000, 5'h02);
        ex(HP, 3);
        ex(FA, 1);
        chk_seq("locked owner", 0);
        ex(HP, 3);
        ex(FA, 1);
        chk_seq("locked owner other", 1);
        $display("test lock done");
    endtask

    // Weight field zero gives 32 beats on the other-slave port, while the SRAM port stops at its limit of 4
    task automatic t_w32();
        cfg(8'h00, 32'h00000100);
        run(bt(0, 33, 1, 0, 0), 30'h00000000, 5'h00);
        ex(HP, 4);
        ex(FA, 1);
        ex(HP, 29);
        chk_seq("weight 32 sram", 0);
        ex(HP, 32);
        ex(FA, 1);
        ex(HP, 1);
        chk_seq("weight 32 other", 1);
        $display("test w32 done");
    endtask

    initial begin
        tick(10);
        i_rst_b <= 1'b1;
        tick(1);
        chk_val("grant idle", 32'h00000000, {27'h0000000, gnt0});
        t_regs();
        t_rr();
        t_skip();
        t_fixed();
        t_weight();
        t_lock();
        t_w32();
        test_done();
    end
endmodule
